//--- rtl/srfb_regs.vh
// constants for the servo response frame builder
`ifndef SRFB_REGS_VH
`define SRFB_REGS_VH
`define SRFB_FRAME_BYTES 16
`define SRFB_DIR_BIT 7
`define SRFB_FAULT_BIT 7
`define SRFB_SEL_DEFAULT_ONE 8'h07
`define SRFB_SEL_DEFAULT_TWO 8'h05
`define SRFB_SEL_DEFAULT_THREE 8'h06
`define SRFB_NORMAL_OPCODE 4'h0
`define SRFB_FIFO_DEPTH 16
`define SRFB_FIFO_AWIDTH 4
`endif

//--- rtl/srfb_fifo.v
// byte fifo between the frame builder and the link transmitter
module srfb_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clock, // system clock
	input wire rstn, // async reset, active low
	input wire [WIDTH-1:0] inData, // write data
	input wire inValid, // write request
	output wire inReady, // not full
	output wire [WIDTH-1:0] outData, // head of queue
	output wire outValid, // not empty
	input wire outReady // consumer takes head
);
	// full level at counter width; a part-select of a plain parameter is not portable
	localparam [AW:0] FULL_LEVEL = DEPTH;
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_r;
	reg [AW-1:0] rdPtr_r;
	reg [AW:0] count_r;
	wire doWrite;
	wire doRead;
	assign inReady = (count_r != FULL_LEVEL);
	assign outValid = (count_r != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_r];
	assign doWrite = inValid & inReady;
	assign doRead = outValid & outReady;
	always @(posedge clock)
	begin
		if (doWrite)
		begin
			mem[wrPtr_r] <= inData;
		end
	end
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (doWrite)
				wrPtr_r <= wrPtr_r + 1'b1;
			if (doRead)
				rdPtr_r <= rdPtr_r + 1'b1;
			if (doWrite & ~doRead)
				count_r <= count_r + 1'b1;
			else if (doRead & ~doWrite)
				count_r <= count_r - 1'b1;
		end
	end
endmodule // srfb_fifo

//--- rtl/srfb_switch_sync.v
// three-stage synchroniser for the address switch, change taken when stages two and three agree
module srfb_switch_sync (
	input wire clock, // system clock
	input wire rstn, // async reset, active low
	input wire [4:0] switchPin, // raw switch level
	output reg [4:0] switchStable // filtered switch value
);
	reg [4:0] s1_r;
	reg [4:0] s2_r;
	reg [4:0] s3_r;
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_r <= 5'h00;
			s2_r <= 5'h00;
			s3_r <= 5'h00;
			switchStable <= 5'h00;
		end
		else
		begin
			s1_r <= switchPin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				switchStable <= s3_r;
		end
	end
endmodule // srfb_switch_sync

//--- rtl/srfb_frame_builder.v
// response frame builder: assembles the 16-byte reply and streams it out byte by byte
`include "srfb_regs.vh"
module srfb_frame_builder (
	input wire clock, // 20 MHz system clock
	input wire rstn, // async reset, active low
	input wire [4:0] rotaryAddressSwitch, // node address switch pin
	input wire cmdStrobe, // one-cycle pulse: a command was received
	input wire cmdFault, // command found in error on reception
	input wire [6:0] cmdOpcode, // command code of received command
	input wire [1:0] cmdUpdateCounter, // update counter of received command
	input wire [3:0] cmdNonCyclic, // non-cyclic command code, 0 = normal
	input wire [31:0] nonCyclicResultTwo, // non-cyclic result for word two
	input wire [31:0] nonCyclicResultThree, // non-cyclic result for word three
	input wire [7:0] monitorChoiceOne, // monitor selector for word one
	input wire [7:0] monitorChoiceTwo, // monitor selector for word two
	input wire [7:0] monitorChoiceThree, // monitor selector for word three
	output reg [7:0] monitorSelOne, // effective selector code, word one
	output reg [7:0] monitorSelTwo, // effective selector code, word two
	output reg [7:0] monitorSelThree, // effective selector code, word three
	input wire [31:0] monitorValueOne, // value for monitorSelOne
	input wire [31:0] monitorValueTwo, // value for monitorSelTwo
	input wire [31:0] monitorValueThree, // value for monitorSelThree
	output reg [7:0] txData, // frame byte toward the link
	output reg txValid, // txData holds a byte
	input wire txReady, // link takes the byte
	output reg txFirst, // byte is frame byte 0
	output reg busy, // a frame is being built or sent
	output reg [4:0] nodeNumber // latched node address
);
	localparam ST_IDLE = 3'b001;
	localparam ST_LOAD = 3'b010;
	localparam ST_PUSH = 3'b100;

	// substitute the documented default when a selector holds zero
	function [7:0] effSel;
		input [7:0] choice;
		input [7:0] dflt;
		begin
			effSel = (choice == 8'h00) ? dflt : choice;
		end
	endfunction

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [7:0] frame_r [0:`SRFB_FRAME_BYTES-1];
	reg [3:0] pushIdx_r;
	reg pendCmd_r;
	reg cmdFault_r;
	reg [6:0] cmdOpcode_r;
	reg [1:0] cmdCounter_r;
	reg [3:0] cmdNonCyclic_r;
	reg nodeLatched_r;
	wire firstWire;
	wire [4:0] switchStable;
	wire [7:0] fifoData;
	wire fifoValid;
	wire fifoInReady;
	wire fifoOutReady;
	wire [31:0] wordOne;
	wire [31:0] wordTwo;
	wire [31:0] wordThree;
	wire [7:0] headerByte;
	wire [7:0] codeByte;
	wire normalCmd;
	wire pushByte;

	srfb_switch_sync uSync (
		.clock(clock),
		.rstn(rstn),
		.switchPin(rotaryAddressSwitch),
		.switchStable(switchStable)
	);

	// node number is caught once, after the synchroniser has settled
	reg [2:0] settle_r;
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			settle_r <= 3'h0;
			nodeLatched_r <= 1'b0;
			nodeNumber <= 5'h00;
		end
		else if (!nodeLatched_r)
		begin
			if (settle_r == 3'h4)
			begin
				nodeNumber <= switchStable;
				nodeLatched_r <= 1'b1;
			end
			else
				settle_r <= settle_r + 3'h1;
		end
	end

	// capture the command; a frame already in flight keeps its own copy
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			pendCmd_r <= 1'b0;
			cmdFault_r <= 1'b0;
			cmdOpcode_r <= 7'h00;
			cmdCounter_r <= 2'h0;
			cmdNonCyclic_r <= 4'h0;
		end
		else
		begin
			if (cmdStrobe)
			begin
				pendCmd_r <= 1'b1;
				cmdFault_r <= cmdFault;
				cmdOpcode_r <= cmdOpcode;
				cmdCounter_r <= cmdUpdateCounter;
				cmdNonCyclic_r <= cmdNonCyclic;
			end
			else if (state_r == ST_LOAD)
				pendCmd_r <= 1'b0;
		end
	end

	// selectors are registered outputs; monitor values return from the data path
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			monitorSelOne <= `SRFB_SEL_DEFAULT_ONE;
			monitorSelTwo <= `SRFB_SEL_DEFAULT_TWO;
			monitorSelThree <= `SRFB_SEL_DEFAULT_THREE;
		end
		else
		begin
			monitorSelOne <= effSel(monitorChoiceOne, `SRFB_SEL_DEFAULT_ONE);
			monitorSelTwo <= effSel(monitorChoiceTwo, `SRFB_SEL_DEFAULT_TWO);
			monitorSelThree <= effSel(monitorChoiceThree, `SRFB_SEL_DEFAULT_THREE);
		end
	end

	assign normalCmd = (cmdNonCyclic_r == `SRFB_NORMAL_OPCODE);
	assign wordOne = monitorValueOne;
	assign wordTwo = normalCmd ? monitorValueTwo : nonCyclicResultTwo;
	assign wordThree = normalCmd ? monitorValueThree : nonCyclicResultThree;
	// bit 7 set marks a response; bits 6..5 echo counter; bits 4..0 node
	assign headerByte = {1'b1, cmdCounter_r, nodeNumber};
	assign codeByte = {cmdFault_r, cmdOpcode_r};

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (pendCmd_r && nodeLatched_r)
					state_nxt = ST_LOAD;
			ST_LOAD:
				state_nxt = ST_PUSH;
			ST_PUSH:
				if (fifoInReady && pushIdx_r == 4'hF)
					state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// frame image; status and input bytes are outside this block and stay zero
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : gWords
			always @(posedge clock)
			begin
				if (state_r == ST_LOAD)
				begin
					frame_r[4 + gi] <= wordOne[8*gi +: 8];
					frame_r[8 + gi] <= wordTwo[8*gi +: 8];
					frame_r[12 + gi] <= wordThree[8*gi +: 8];
				end
			end
		end
	endgenerate

	always @(posedge clock)
	begin
		if (state_r == ST_LOAD)
		begin
			frame_r[0] <= headerByte;
			frame_r[1] <= codeByte;
			frame_r[2] <= 8'h00;
			frame_r[3] <= 8'h00;
		end
	end

	assign pushByte = (state_r == ST_PUSH) && fifoInReady;

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= ST_IDLE;
			pushIdx_r <= 4'h0;
			busy <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			busy <= (state_nxt != ST_IDLE) || fifoValid || txValid;
			if (state_r == ST_LOAD)
				pushIdx_r <= 4'h0;
			else if (pushByte)
				pushIdx_r <= pushIdx_r + 4'h1;
		end
	end

	// the fifo holds one whole frame, so a build into an empty fifo never waits on the wire; ST_PUSH stalls while it is full
	srfb_fifo #(
		.WIDTH(9),
		.DEPTH(`SRFB_FIFO_DEPTH),
		.AW(`SRFB_FIFO_AWIDTH)
	) uFifo (
		.clock(clock),
		.rstn(rstn),
		.inData({(pushIdx_r == 4'h0), frame_r[pushIdx_r]}),
		.inValid(state_r == ST_PUSH),
		.inReady(fifoInReady),
		.outData({firstWire, fifoData}),
		.outValid(fifoValid),
		.outReady(fifoOutReady)
	);

	// output stage register keeps every port driven from a flip-flop
	assign fifoOutReady = ~txValid | txReady;
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			txData <= 8'h00;
			txValid <= 1'b0;
			txFirst <= 1'b0;
		end
		else if (fifoOutReady)
		begin
			txValid <= fifoValid;
			txData <= fifoValid ? fifoData : 8'h00;
			txFirst <= fifoValid & firstWire;
		end
	end
endmodule // srfb_frame_builder

//--- test/srfb_assertions.sv
// port assertions for the response frame builder
module srfb_assertions (
	input wire clock, // clock
	input wire rstn, // reset
	input wire cmdStrobe, // command taken
	input wire busy, // frame active
	input wire [7:0] monitorChoiceOne, // choice 1
	input wire [7:0] monitorChoiceTwo, // choice 2
	input wire [7:0] monitorChoiceThree, // choice 3
	input wire [7:0] monitorSelOne, // sel 1
	input wire [7:0] monitorSelTwo, // sel 2
	input wire [7:0] monitorSelThree, // sel 3
	input wire [7:0] txData, // byte
	input wire txValid, // byte offered
	input wire txReady, // byte taken
	input wire txFirst, // byte 0
	input wire [4:0] nodeNumber // node
);
	reg [4:0] takenCnt_r;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// bytes taken from the last header byte on, the header byte counted as one
	always @(posedge clock or negedge rstn)
		if (!rstn)
			takenCnt_r <= 5'h00;
		else if (txValid && txReady)
			takenCnt_r <= txFirst ? 5'h01 : takenCnt_r + 5'h01;
	property p_selOne; $past(rstn) && $past(monitorChoiceOne) == 8'h00 |-> monitorSelOne == 8'h07;
	endproperty
	property p_selTwo; $past(rstn) && $past(monitorChoiceTwo) == 8'h00 |-> monitorSelTwo == 8'h05;
	endproperty
	property p_selThree;
		$past(rstn) && $past(monitorChoiceThree) == 8'h00 |-> monitorSelThree == 8'h06;
	endproperty
	property p_head; txValid && txFirst |-> txData[7] && txData[4:0] == nodeNumber; endproperty
	property p_hold; txValid && !txReady |=> txValid && $stable(txData) && $stable(txFirst);
	endproperty
	property p_len; txValid && txFirst |-> takenCnt_r == 5'h00 || takenCnt_r == 5'h10; endproperty
	property p_zero;
		txValid && !txFirst && (takenCnt_r == 5'h02 || takenCnt_r == 5'h03) |-> txData == 8'h00;
	endproperty
	property p_start; cmdStrobe && !busy |-> ##[3:20] txValid && txFirst; endproperty
	a_selOne: assert property (p_selOne) else $error("word one default wrong");
	a_selTwo: assert property (p_selTwo) else $error("word two default wrong");
	a_selThree: assert property (p_selThree) else $error("word three default wrong");
	a_head: assert property (p_head) else $error("header byte wrong");
	a_hold: assert property (p_hold) else $error("byte dropped while stalled");
	a_len: assert property (p_len) else $error("frame length wrong");
	a_zero: assert property (p_zero) else $error("unused byte not zero");
	a_start: assert property (p_start) else $error("no frame after command");
	c_stall: cover property (txValid && txFirst && !txReady);
	c_last: cover property (txValid && txReady && takenCnt_r == 5'h0F);
	c_dflt: cover property (monitorChoiceTwo == 8'h00 && monitorSelTwo == 8'h05);
endmodule // srfb_assertions
bind srfb_frame_builder srfb_assertions chk_u (.clock, .rstn, .cmdStrobe, .busy,
	.monitorChoiceOne, .monitorChoiceTwo, .monitorChoiceThree, .monitorSelOne,
	.monitorSelTwo, .monitorSelThree, .txData, .txValid, .txReady, .txFirst, .nodeNumber);

//--- test/srfb_link_model.sv
// host-side link receiver: collects response bytes, stalls at random when slow
module srfb_link_model (
	input wire clock, // clock
	input wire slow, // random stalls
	input wire [7:0] txData, // byte
	input wire txValid, // byte offered
	input wire txFirst, // byte 0
	output reg txReady // byte taken
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [7:0] frm [0:15];
	integer idx = 0, nFrames = 0, seed = 32'h00005EED;
	initial txReady = 1'h0;
	// only listens; the host never drives the response
	always @(posedge clock)
	begin
		if (txValid && txReady)
		begin
			idx = txFirst ? 0 : idx + 1;
			frm[idx] = txData;
			if (idx == 15)
				nFrames = nFrames + 1;
		end
		#5 txReady = slow ? $random(seed) : 1'h1;
	end
endmodule // srfb_link_model

//--- test/srfb_frame_builder_tb.sv
// self-checking bench for the response frame builder
module srfb_frame_builder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	function [31:0] mval(input [7:0] s);
		mval = {s, ~s, s ^ 8'h5A, 8'hC3};
	endfunction
	function [7:0] eff(input [7:0] c, input [7:0] d);
		eff = (c == 8'h00) ? d : c;
	endfunction
	reg clock = 1'h0, rstn = 1'h0, cmdStrobe = 1'h0, cmdFault = 1'h0, slow = 1'h0;
	reg [4:0] rotaryAddressSwitch, node;
	reg [6:0] cmdOpcode = 7'h00;
	reg [1:0] cmdUpdateCounter = 2'h0;
	reg [3:0] cmdNonCyclic = 4'h0;
	reg [31:0] nonCyclicResultTwo = 32'h0, nonCyclicResultThree = 32'h0, w1, w2, w3;
	reg [7:0] monitorChoiceOne = 8'h00, monitorChoiceTwo = 8'h00, monitorChoiceThree = 8'h00;
	reg [7:0] want [0:15];
	wire [7:0] monitorSelOne, monitorSelTwo, monitorSelThree, txData;
	wire [4:0] nodeNumber;
	wire txValid, txReady, txFirst, busy;
	wire [31:0] monitorValueOne = mval(monitorSelOne);
	wire [31:0] monitorValueTwo = mval(monitorSelTwo);
	wire [31:0] monitorValueThree = mval(monitorSelThree);
	integer fails = 0, n_compared = 0, seed = 32'hA2AD181D, i, k, t, n0;
	srfb_frame_builder dut_u (.*);
	srfb_link_model link_u (.clock, .slow, .txData, .txValid, .txFirst, .txReady);
	initial
		forever #25 clock = ~clock;
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp)
			begin
				fails = fails + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("compared %0d, mismatches %0d", n_compared, fails);
			if (fails == 0 && n_compared > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task frame;
		begin
			w1 = mval(eff(monitorChoiceOne, 8'h07));
			w2 = cmdNonCyclic ? nonCyclicResultTwo : mval(eff(monitorChoiceTwo, 8'h05));
			w3 = cmdNonCyclic ? nonCyclicResultThree : mval(eff(monitorChoiceThree, 8'h06));
			want[0] = {1'h1, cmdUpdateCounter, node};
			want[1] = {cmdFault, cmdOpcode};
			want[2] = 8'h00;
			want[3] = 8'h00;
			for (k = 0; k < 4; k = k + 1)
				{want[12 + k], want[8 + k], want[4 + k]} = {w3[8*k+:8], w2[8*k+:8], w1[8*k+:8]};
			for (t = 0; t < 200 && busy !== 1'h0; t = t + 1)
				@(posedge clock);
			if (t == 200)
			begin
				fails = fails + 1;
				$display("wrong value at %0t: stuck busy", $time);
				give_verdict;
			end
			n0 = link_u.nFrames;
			@(posedge clock);
			#5 cmdStrobe = 1'h1;
			@(posedge clock);
			#5 cmdStrobe = 1'h0;
			for (t = 0; t < 400 && link_u.nFrames == n0; t = t + 1)
				@(posedge clock);
			#5;
			if (t == 400)
			begin
				fails = fails + 1;
				$display("wrong value at %0t: no frame", $time);
				give_verdict;
			end
			for (k = 0; k < 16; k = k + 1)
				chk(link_u.frm[k], want[k]);
		end
	endtask
	initial
	begin
		node = $random(seed);
		rotaryAddressSwitch = node;
		repeat (2) @(posedge clock);
		#5 rstn = 1'h1;
		for (i = 0; i < 40; i = i + 1)
		begin
			{cmdOpcode, cmdUpdateCounter, cmdFault, cmdNonCyclic} = $random(seed);
			if (i % 3)
				cmdNonCyclic = 4'h0;
			nonCyclicResultTwo = $random(seed);
			nonCyclicResultThree = $random(seed);
			{monitorChoiceOne, monitorChoiceTwo, monitorChoiceThree} =
				i < 2 ? 24'h000000 : i == 2 ? 24'hFFFFFF : $random(seed);
			slow = i[0];
			// a switch change after the latch must not reach the header
			if (i == 20)
				rotaryAddressSwitch = ~node;
			frame;
		end
		chk({3'h0, nodeNumber}, {3'h0, node});
		give_verdict;
	end
endmodule // srfb_frame_builder_tb
